// ===== pcr_port_one_ctrl.sv
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "pcr_map.svh"

module pcr_port_one_ctrl (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Register port.
  input  wire pcr_pkg::pcr_addr_t addr_i,
  input  wire pcr_pkg::pcr_word_t wr_data_i,
  input  wire logic              wr_stb_i,
  input  wire logic              rd_stb_i,
  output      pcr_pkg::pcr_word_t rd_data_o,
  // Port one controls.
  output      logic              port_one_power_en_o,
  output      logic              port_one_init_flag_o,
  output      logic              port_one_ready_o
);
  import pcr_pkg::*;

  // Interfaces to the two stored halves.
  pcr_store_if hi_if ();
  pcr_store_if lo_if ();

  // Decode and write shaping.
  logic      sel_ctrl;
  logic      wr_hit;
  logic      rd_hit;
  logic      trig_wr;
  pcr_half_t hi_wr_val;
  pcr_half_t lo_wr_val;

  // Registered outputs and their next values.
  pcr_word_t rd_data_r;
  pcr_word_t rd_data_nxt;
  logic      power_en_r;
  logic      power_en_nxt;
  logic      flag_out_r;
  logic      flag_out_nxt;
  logic      ready_r;
  logic      ready_nxt;

  // Initialisation progress.
  pcr_init_e init_state_r;
  pcr_init_e init_state_nxt;

  // The value that every addressed read shows in both halves.
  pcr_half_t view_half;

  // Address decode of the single control word.
  always_comb begin
    sel_ctrl = (addr_i == `PCR_CTRL_OFS);
    wr_hit   = wr_stb_i && sel_ctrl;
    rd_hit   = rd_stb_i && sel_ctrl;
    trig_wr  = wr_hit && wr_data_i[`PCR_TRIG_BIT];
  end

  // Shape the written word before it reaches storage.
  // The trigger stays set only from reset until the first addressed write, and it overrides any flag value written beside it.
  always_comb begin
    hi_wr_val = wr_data_i[31:16];
    lo_wr_val = wr_data_i[15:0];
    hi_wr_val[`PCR_HALF_TRIG_BIT] = 1'b0;
    if (wr_data_i[`PCR_TRIG_BIT]) begin
      lo_wr_val[`PCR_HALF_FLAG_BIT] = 1'b0;
    end
  end

  // Both halves take a write only when the control word is addressed.
  assign hi_if.wr_en   = wr_hit;
  assign hi_if.wr_data = hi_wr_val;
  assign lo_if.wr_en   = wr_hit;
  assign lo_if.wr_data = lo_wr_val;

  // Upper half: trigger and reserved bits.
  pcr_half_store #(
    .RESET_VAL (`PCR_RST_HI)
  ) u_hi_store (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .bus_if  (hi_if.store)
  );

  // Lower half: flag, power field and reserved bits.
  pcr_half_store #(
    .RESET_VAL (`PCR_RST_LO)
  ) u_lo_store (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .bus_if  (lo_if.store)
  );

  // The lower half is the visible value; it is mirrored into the upper half on read.
  assign view_half = lo_if.q;

  // Read data for the cycle after the strobe; unmapped reads answer zero.
  always_comb begin
    rd_data_nxt = `PCR_UNMAPPED_DATA;
    if (rd_hit) begin
      rd_data_nxt = {view_half, view_half};
    end
  end

  // Port one control outputs follow the stored lower half and the init state one cycle later.
  // The flag and the ready level drive port one only; no other port sees them.
  always_comb begin
    power_en_nxt = (lo_if.q[`PCR_PWR_MSB:`PCR_PWR_LSB] == `PCR_PWR_ON);
    flag_out_nxt = lo_if.q[`PCR_FLAG_BIT];
    ready_nxt    = (init_state_r == PCR_INIT_DONE) && !lo_if.q[`PCR_FLAG_BIT];
  end

  // Initialisation progress: a trigger write marks the sequence as done.
  always_comb begin
    init_state_nxt = init_state_r;
    case (init_state_r)
      PCR_INIT_PENDING: begin
        if (trig_wr) begin
          init_state_nxt = PCR_INIT_DONE;
        end
      end
      PCR_INIT_DONE: begin
        init_state_nxt = PCR_INIT_DONE;
      end
      default: begin
        init_state_nxt = PCR_INIT_PENDING;
      end
    endcase
  end

  // Output and state registers.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_r    <= `PCR_UNMAPPED_DATA;
      power_en_r   <= 1'b0;
      flag_out_r   <= 1'b0;
      ready_r      <= 1'b0;
      init_state_r <= PCR_INIT_PENDING;
    end else begin
      rd_data_r    <= rd_data_nxt;
      power_en_r   <= power_en_nxt;
      flag_out_r   <= flag_out_nxt;
      ready_r      <= ready_nxt;
      init_state_r <= init_state_nxt;
    end
  end

  assign rd_data_o            = rd_data_r;
  assign port_one_power_en_o  = power_en_r;
  assign port_one_init_flag_o = flag_out_r;
  assign port_one_ready_o     = ready_r;

  // Assertions share the single clock and reset.
  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (!rst_n_i);

  // Any read of the word shows identical halves in the answer cycle.
  AST_MIRROR_HALVES: assert property (
    rd_hit |=> (rd_data_o[31:16] == rd_data_o[15:0]))
    else $error("Read answer halves differ.");

  // The answer of a read equals the stored lower half taken at the strobe.
  AST_READ_VALUE: assert property (
    rd_hit |=> (rd_data_o == {$past(lo_if.q), $past(lo_if.q)}))
    else $error("Read answer does not match stored value.");

  // A trigger write leaves both trigger and flag clear.
  AST_TRIG_CLEARS: assert property (
    trig_wr |=> (!hi_if.q[`PCR_HALF_TRIG_BIT] && !lo_if.q[`PCR_HALF_FLAG_BIT]))
    else $error("Trigger write did not clear trigger and flag.");

  // A read right after a trigger write sees the flag cleared in both halves.
  AST_TRIG_READBACK: assert property (
    trig_wr ##1 rd_hit |=> (!rd_data_o[`PCR_FLAG_BIT] && !rd_data_o[`PCR_TRIG_BIT]))
    else $error("Flag still reads one after trigger write.");

  // The ready level is never shown while the flag is set.
  AST_READY_NEEDS_CLEAR: assert property (
    port_one_ready_o |-> !port_one_init_flag_o)
    else $error("Port one ready while init flag is set.");

  // Two cycles after a trigger write with no further write, port one is ready.
  AST_READY_AFTER_TRIG: assert property (
    trig_wr ##1 !wr_hit |=> port_one_ready_o)
    else $error("Port one not ready after trigger write.");

  // The flag only moves on a write that addresses the control word.
  AST_FLAG_LOCAL: assert property (
    !$stable(lo_if.q[`PCR_HALF_FLAG_BIT]) |-> $past(wr_hit))
    else $error("Init flag changed without a control write.");

  // Power follows the field one cycle late, on for 11b only.
  AST_PWR_ON: assert property (
    (lo_if.q[`PCR_PWR_MSB:`PCR_PWR_LSB] == `PCR_PWR_ON) |=> port_one_power_en_o)
    else $error("Port power off with field at 11b.");

  AST_PWR_OFF: assert property (
    (lo_if.q[`PCR_PWR_MSB:`PCR_PWR_LSB] != `PCR_PWR_ON) |=> !port_one_power_en_o)
    else $error("Port power on with field not at 11b.");

  // An unmapped read answers zero.
  AST_UNMAPPED_ZERO: assert property (
    (rd_stb_i && !sel_ctrl) |=> (rd_data_o == `PCR_UNMAPPED_DATA))
    else $error("Unmapped read returned nonzero data.");

  // Outside the answer cycle of an addressed read, the read data are zero.
  AST_RD_IDLE_ZERO: assert property (
    !rd_hit |=> (rd_data_o == `PCR_UNMAPPED_DATA))
    else $error("Read data nonzero outside the answer cycle.");

  // The lower half holds its value when no write addresses the word.
  AST_LO_HOLDS: assert property (
    !wr_hit |=> $stable(lo_if.q))
    else $error("Lower half changed without a control write.");

  // The upper half holds its value when no write addresses the word.
  AST_HI_HOLDS: assert property (
    !wr_hit |=> $stable(hi_if.q))
    else $error("Upper half changed without a control write.");

  // A write to another address leaves both halves untouched.
  AST_UNMAPPED_WRITE: assert property (
    (wr_stb_i && !sel_ctrl) |=> ($stable(lo_if.q) && $stable(hi_if.q)))
    else $error("Unmapped write changed the control word.");

  // A write without the trigger stores the lower half exactly as written.
  AST_LO_WRITE_LANDS: assert property (
    (wr_hit && !wr_data_i[`PCR_TRIG_BIT]) |=> (lo_if.q == $past(wr_data_i[15:0])))
    else $error("Lower half does not match the written value.");

  // A trigger write stores every lower bit but the flag as written.
  AST_TRIG_KEEPS_REST: assert property (
    trig_wr |=> ((lo_if.q[15:`PCR_HALF_FLAG_BIT+1] == $past(wr_data_i[15:`PCR_FLAG_BIT+1])) &&
                 (lo_if.q[`PCR_HALF_FLAG_BIT-1:0] == $past(wr_data_i[`PCR_FLAG_BIT-1:0]))))
    else $error("Trigger write disturbed bits beside the flag.");

  // Every addressed write stores the upper bits beside the trigger as written.
  AST_HI_WRITE_LANDS: assert property (
    wr_hit |=> ((hi_if.q[15:`PCR_HALF_TRIG_BIT+1] == $past(wr_data_i[31:`PCR_TRIG_BIT+1])) &&
                (hi_if.q[`PCR_HALF_TRIG_BIT-1:0] == $past(wr_data_i[`PCR_TRIG_BIT-1:16]))))
    else $error("Upper half does not match the written value.");

  // The flag output shows the stored flag one cycle late.
  AST_FLAG_FOLLOWS: assert property (
    1'b1 |=> (port_one_init_flag_o == $past(lo_if.q[`PCR_FLAG_BIT])))
    else $error("Flag output does not follow the stored flag.");

  // Power is only shown when the field held 11b one cycle before.
  AST_PWR_NEEDS_BOTH: assert property (
    port_one_power_en_o |-> ($past(lo_if.q[`PCR_PWR_MSB:`PCR_PWR_LSB]) == `PCR_PWR_ON))
    else $error("Port power on without both field bits set.");

  // A trigger write marks initialisation as done.
  AST_TRIG_DONE: assert property (
    trig_wr |=> (init_state_r == PCR_INIT_DONE))
    else $error("Trigger write did not complete initialisation.");

  // Without a trigger write, initialisation stays pending.
  AST_PENDING_HOLDS: assert property (
    ((init_state_r == PCR_INIT_PENDING) && !trig_wr) |=> (init_state_r == PCR_INIT_PENDING))
    else $error("Initialisation completed without a trigger write.");

  // Port one is never ready before a trigger write.
  AST_READY_NEEDS_TRIG: assert property (
    (init_state_r == PCR_INIT_PENDING) |=> !port_one_ready_o)
    else $error("Port one ready before any trigger write.");

  // Once initialised with the flag clear, port one shows ready a cycle later.
  AST_READY_ON: assert property (
    ((init_state_r == PCR_INIT_DONE) && !lo_if.q[`PCR_FLAG_BIT]) |=> port_one_ready_o)
    else $error("Port one not ready although initialised.");

  // The recommended start-up word is written.
  COV_INIT_WORD: cover property (
    wr_hit && (wr_data_i == `PCR_INIT_WORD));

  // The start-up word enables power two cycles later.
  COV_INIT_POWER: cover property (
    (wr_hit && (wr_data_i == `PCR_INIT_WORD)) ##2 port_one_power_en_o);

  // A read follows a trigger write back to back.
  COV_TRIG_THEN_READ: cover property (
    trig_wr ##1 rd_hit);

  // Port one becomes ready.
  COV_READY: cover property (
    !port_one_ready_o ##1 port_one_ready_o);

  // Software sets the flag again without the trigger.
  COV_FLAG_WRITTEN: cover property (
    wr_hit && wr_data_i[`PCR_FLAG_BIT] && !wr_data_i[`PCR_TRIG_BIT]);

endmodule : pcr_port_one_ctrl

// ===== pcr_map.svh
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// Byte address of the port one control word.
`define PCR_CTRL_OFS        16'h0374

// Field positions inside the 32-bit word.
`define PCR_TRIG_BIT        23
`define PCR_FLAG_BIT        7
`define PCR_PWR_MSB         4
`define PCR_PWR_LSB         3

// Positions of trigger and flag inside their own 16-bit half.
`define PCR_HALF_TRIG_BIT   7
`define PCR_HALF_FLAG_BIT   7

// Reset values of the two stored halves.
`define PCR_RST_HI          16'h0086
`define PCR_RST_LO          16'h0016

// Power field value that switches port power on.
`define PCR_PWR_ON          2'h3

// Word that software writes once after power-on.
`define PCR_INIT_WORD       32'h0080_0018

// Read answer for an address that holds no register.
`define PCR_UNMAPPED_DATA   32'h0000_0000

`endif

// ===== pcr_pkg.sv
package pcr_pkg;

  // One 16-bit half of the control word.
  typedef logic [15:0] pcr_half_t;

  // The full bus word.
  typedef logic [31:0] pcr_word_t;

  // Register bus address.
  typedef logic [15:0] pcr_addr_t;

  // Progress of the port one initialisation sequence.
  typedef enum logic [0:0] {
    PCR_INIT_PENDING,
    PCR_INIT_DONE
  } pcr_init_e;

endpackage : pcr_pkg

// ===== pcr_store_if.sv
`timescale 1ns/10ps

// Write port and stored value of one 16-bit half of the control word.
interface pcr_store_if;
  import pcr_pkg::*;

  logic      wr_en;
  pcr_half_t wr_data;
  pcr_half_t q;

  // The control logic drives writes and reads the stored value.
  modport owner (
    output wr_en,
    output wr_data,
    input  q
  );

  // The storage takes writes and presents its value.
  modport store (
    input  wr_en,
    input  wr_data,
    output q
  );

endinterface : pcr_store_if

// ===== pcr_half_store.sv
`timescale 1ns/10ps

module pcr_half_store #(
  parameter pcr_pkg::pcr_half_t RESET_VAL = 16'h0000
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Write port and stored value.
  pcr_store_if.store bus_if
);
  import pcr_pkg::*;

  pcr_half_t q_r;
  pcr_half_t q_nxt;

  // A write replaces the whole half; otherwise the value holds.
  always_comb begin
    q_nxt = q_r;
    if (bus_if.wr_en) begin
      q_nxt = bus_if.wr_data;
    end
  end

  // The stored half starts from its reset value.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= RESET_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign bus_if.q = q_r;

endmodule : pcr_half_store

// ===== pcr_port_one_ctrl_test.sv
`timescale 1ns/10ps
`include "pcr_map.svh"

module pcr_port_one_ctrl_test;
  import pcr_pkg::*;

  // Clock, reset and register port drive.
  logic      clk_i;
  logic      rst_n_i;
  pcr_addr_t addr_i;
  pcr_word_t wr_data_i;
  logic      wr_stb_i;
  logic      rd_stb_i;
  pcr_word_t rd_data_o;
  logic      port_one_power_en_o;
  logic      port_one_init_flag_o;
  logic      port_one_ready_o;
  int        n_fail;
  int        n_tests;

  // Block under test.
  pcr_port_one_ctrl uut (
    .clk_i                (clk_i),
    .rst_n_i              (rst_n_i),
    .addr_i               (addr_i),
    .wr_data_i            (wr_data_i),
    .wr_stb_i             (wr_stb_i),
    .rd_stb_i             (rd_stb_i),
    .rd_data_o            (rd_data_o),
    .port_one_power_en_o  (port_one_power_en_o),
    .port_one_init_flag_o (port_one_init_flag_o),
    .port_one_ready_o     (port_one_ready_o)
  );

  // Free-running 50 MHz clock.
  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  // Compares one value and reports a mismatch at once.
  task automatic chk(input pcr_word_t seen, input pcr_word_t exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // One-cycle write strobe; returns at the edge that takes it.
  task automatic wr(input pcr_addr_t a, input pcr_word_t d);
    @(posedge clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_stb_i  <= 1'b1;
    @(posedge clk_i);
    wr_stb_i  <= 1'b0;
  endtask : wr

  // One-cycle read; data stand only in the cycle after the strobe.
  task automatic rd(input pcr_addr_t a, input pcr_word_t exp);
    @(posedge clk_i);
    addr_i   <= a;
    rd_stb_i <= 1'b1;
    @(posedge clk_i);
    rd_stb_i <= 1'b0;
    #1;
    chk(rd_data_o, exp);
    @(posedge clk_i);
    #1;
    chk(rd_data_o, 32'h0000_0000);
  endtask : rd

  // Write then read the control word back to back, with no idle cycle between strobes.
  task automatic wr_rd(input pcr_word_t d, input pcr_word_t exp);
    @(posedge clk_i);
    addr_i    <= `PCR_CTRL_OFS;
    wr_data_i <= d;
    wr_stb_i  <= 1'b1;
    @(posedge clk_i);
    wr_stb_i  <= 1'b0;
    rd_stb_i  <= 1'b1;
    @(posedge clk_i);
    rd_stb_i  <= 1'b0;
    #1;
    chk(rd_data_o, exp);
  endtask : wr_rd

  // Lets stored changes reach the port one outputs, then compares them.
  task automatic ports(input logic pwr, input logic flag, input logic rdy);
    repeat (2) @(posedge clk_i);
    #1;
    chk({31'h0, port_one_power_en_o}, {31'h0, pwr});
    chk({31'h0, port_one_init_flag_o}, {31'h0, flag});
    chk({31'h0, port_one_ready_o}, {31'h0, rdy});
  endtask : ports

  // Holds reset low for two clock cycles.
  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask : do_reset

  // Main sequence; reserved low bits are written with their reset value 110b, except in the start-up word, which has 000b.
  initial begin
    n_fail    = 0;
    n_tests   = 0;
    rst_n_i   = 1'b0;
    addr_i    = 16'h0000;
    wr_data_i = 32'h0000_0000;
    wr_stb_i  = 1'b0;
    rd_stb_i  = 1'b0;
    @(posedge clk_i);
    do_reset();
    ports(1'b0, 1'b0, 1'b0);
    rd(`PCR_CTRL_OFS, 32'h0016_0016);
    wr(`PCR_CTRL_OFS, 32'h0000_008E);
    ports(1'b0, 1'b1, 1'b0);
    rd(`PCR_CTRL_OFS, 32'h008E_008E);
    wr(`PCR_CTRL_OFS, 32'h0000_009E);
    ports(1'b1, 1'b1, 1'b0);
    wr(`PCR_CTRL_OFS, 32'h0080_009E);
    ports(1'b1, 1'b0, 1'b1);
    rd(`PCR_CTRL_OFS, 32'h001E_001E);
    wr(`PCR_CTRL_OFS, 32'h0000_008E);
    ports(1'b0, 1'b1, 1'b0);
    wr_rd(32'h0086_009E, 32'h001E_001E);
    ports(1'b1, 1'b0, 1'b1);
    wr(`PCR_CTRL_OFS, `PCR_INIT_WORD);
    ports(1'b1, 1'b0, 1'b1);
    rd(`PCR_CTRL_OFS, 32'h0018_0018);
    // An unmapped address neither stores nor answers.
    wr(16'h0378, 32'h0000_0000);
    ports(1'b1, 1'b0, 1'b1);
    rd(16'h0378, 32'h0000_0000);
    // A second reset in mid-run restores the reset state.
    @(posedge clk_i);
    do_reset();
    ports(1'b0, 1'b0, 1'b0);
    rd(`PCR_CTRL_OFS, 32'h0016_0016);
    tally_and_finish();
  end

  // Watchdog: the sequence needs well under 200 cycles.
  initial begin
    repeat (2000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end

endmodule : pcr_port_one_ctrl_test
